/* rtl/olbc_defs.vh */
// Constants for the banked per-channel configuration block
// Summary of operation
// - Pointer 00 primary, AA secondary, 01 individual, 02 tester bank.
// - The 8-bit bank pointer steers every banked register access.
// - Bit n-1 of each register serves channel n; all bits reset zero.
// - Rail-select bit one gives single rail, zero gives dual rail.
// - Line-code bit one gives AMI, zero B8ZS/HDB3; global override ignores it.
// - Receive power-down bit one powers down that channel's receiver.
// - Transmit power-down bit one powers down that channel's transmitter.
// - Excess-zero detect bit enables detection, only single rail with HDB3/B8ZS.
// - Violation-detect disable bit one disables; HDB3 only; code override suppresses.
// - Jitter attenuator enable per channel, ignored while global enable set.
// - Position bit one puts attenuator in receive path, zero transmit; global overrides.
// - Depth bit one selects 128 bits, zero 32; global depth bit overrides.
`ifndef OLBC_DEFS_VH
`define OLBC_DEFS_VH

// ----------------------------------------
// Bank pointer codes
// ----------------------------------------
`define OLBC_BANK_PRIMARY 8'h00
`define OLBC_BANK_SECONDARY 8'hAA
`define OLBC_BANK_INDIVIDUAL 8'h01
`define OLBC_BANK_TESTER 8'h02

// ----------------------------------------
// Offsets
// ----------------------------------------
`define OLBC_OFS_BANK_POINTER 8'h1F
`define OLBC_OFS_GLOBAL_CONTROL 8'h1E
`define OLBC_OFS_SINGLE_RAIL 8'h00
`define OLBC_OFS_LINE_CODE 8'h01
`define OLBC_OFS_RX_POWER_DOWN 8'h03
`define OLBC_OFS_TX_POWER_DOWN 8'h04
`define OLBC_OFS_EXCESS_ZERO 8'h05
`define OLBC_OFS_CODE_VIOL_DIS 8'h06
`define OLBC_OFS_JA_ENABLE 8'h00
`define OLBC_OFS_JA_POSITION 8'h01
`define OLBC_OFS_JA_DEPTH 8'h02

// ----------------------------------------
// Global control fields and reset values
// ----------------------------------------
`define OLBC_GLOBAL_CODE_OVERRIDE_BIT 0
`define OLBC_GLOBAL_JITTER_ATTEN_ENABLE_BIT 1
`define OLBC_GC_DEPTH_BIT 2
`define OLBC_GC_WIDTH 3
`define OLBC_RESET_BYTE 8'h00
`define OLBC_RESET_GC 3'h0

// ----------------------------------------
// Register slot indices in the storage array
// ----------------------------------------
`define OLBC_SLOT_SINGLE_RAIL 4'h0
`define OLBC_SLOT_LINE_CODE 4'h1
`define OLBC_SLOT_RX_POWER_DOWN 4'h2
`define OLBC_SLOT_TX_POWER_DOWN 4'h3
`define OLBC_SLOT_EXCESS_ZERO 4'h4
`define OLBC_SLOT_CODE_VIOL_DIS 4'h5
`define OLBC_SLOT_JA_ENABLE 4'h6
`define OLBC_SLOT_JA_POSITION 4'h7
`define OLBC_SLOT_JA_DEPTH 4'h8
`define OLBC_SLOT_NONE 4'hF
`define OLBC_SLOT_COUNT 9

`endif

/* rtl/olbc_reg_store.v */
// Nine-byte configuration store with per-slot outputs
`timescale 1ns/100ps
module olbc_reg_store (
  input wire clock,
  input wire srst,
  input wire wrEn,
  input wire [3:0] wrSlot,
  input wire [7:0] wrData,
  output wire [71:0] allBytes
);
`include "olbc_defs.vh"

  reg [7:0] mem_q [0:`OLBC_SLOT_COUNT-1];
  integer i;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always @(posedge clock) begin
    if (srst) begin
      for (i = 0; i < `OLBC_SLOT_COUNT; i = i + 1) begin
        mem_q[i] <= `OLBC_RESET_BYTE;
      end
    end else if (wrEn && (wrSlot < `OLBC_SLOT_COUNT)) begin
      mem_q[wrSlot] <= wrData;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `OLBC_SLOT_COUNT; g = g + 1) begin : gOut
      assign allBytes[g*8 +: 8] = mem_q[g];
    end
  endgenerate
endmodule // olbc_reg_store

/* rtl/olbc_channel_config.v */
// Banked per-channel configuration registers for an eight-channel line interface
`timescale 1ns/100ps
module olbc_channel_config (
  input wire clock,
  input wire srst,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdData,
  output reg [7:0] bankPointer,
  output reg [7:0] singleRail,
  output reg [7:0] amiCoding,
  output reg [7:0] rxPowerDown,
  output reg [7:0] txPowerDown,
  output reg [7:0] excessZeroDetect,
  output reg [7:0] codeViolDetect,
  output reg [7:0] jitterAttenOn,
  output reg [7:0] jitterAttenRxPath,
  output reg [7:0] jitterDepth128,
  output reg [2:0] globalControl
);
`include "olbc_defs.vh"

  wire [71:0] allBytes;
  reg [7:0] bankPointer_d;
  reg [2:0] globalControl_d;
  reg [3:0] wrSlot;
  reg [3:0] rdSlot;
  reg [7:0] rdData_d;
  wire codeOverride;
  wire jaGlobal;
  wire depthGlobal;
  wire [7:0] srByte;
  wire [7:0] lcByte;
  wire [7:0] rpByte;
  wire [7:0] tpByte;
  wire [7:0] ezByte;
  wire [7:0] cvByte;
  wire [7:0] jeByte;
  wire [7:0] jpByte;
  wire [7:0] jdByte;
  wire storeWrEn;
  wire ptrHit;
  wire gcHit;
  reg [7:0] singleRail_d;
  reg [7:0] amiCoding_d;
  reg [7:0] rxPowerDown_d;
  reg [7:0] txPowerDown_d;
  reg [7:0] excessZeroDetect_d;
  reg [7:0] codeViolDetect_d;
  reg [7:0] jitterAttenOn_d;
  reg [7:0] jitterAttenRxPath_d;
  reg [7:0] jitterDepth128_d;
  reg [7:0] amiEffective;

  // ----------------------------------------
  // Bank and offset decode
  // ----------------------------------------
  // Primary and tester banks live elsewhere, so they map to no slot here
  function [3:0] slotOf;
    input [7:0] bank;
    input [7:0] ofs;
    begin
      slotOf = `OLBC_SLOT_NONE;
      if (bank == `OLBC_BANK_SECONDARY) begin
        case (ofs)
          `OLBC_OFS_SINGLE_RAIL: slotOf = `OLBC_SLOT_SINGLE_RAIL;
          `OLBC_OFS_LINE_CODE: slotOf = `OLBC_SLOT_LINE_CODE;
          `OLBC_OFS_RX_POWER_DOWN: slotOf = `OLBC_SLOT_RX_POWER_DOWN;
          `OLBC_OFS_TX_POWER_DOWN: slotOf = `OLBC_SLOT_TX_POWER_DOWN;
          `OLBC_OFS_EXCESS_ZERO: slotOf = `OLBC_SLOT_EXCESS_ZERO;
          `OLBC_OFS_CODE_VIOL_DIS: slotOf = `OLBC_SLOT_CODE_VIOL_DIS;
          default: slotOf = `OLBC_SLOT_NONE;
        endcase
      end else if (bank == `OLBC_BANK_INDIVIDUAL) begin
        case (ofs)
          `OLBC_OFS_JA_ENABLE: slotOf = `OLBC_SLOT_JA_ENABLE;
          `OLBC_OFS_JA_POSITION: slotOf = `OLBC_SLOT_JA_POSITION;
          `OLBC_OFS_JA_DEPTH: slotOf = `OLBC_SLOT_JA_DEPTH;
          default: slotOf = `OLBC_SLOT_NONE;
        endcase
      end
    end
  endfunction

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  // Unbanked offsets bypass the store in every bank
  function isUnbanked;
    input [7:0] ofs;
    begin
      isUnbanked = 1'b0;
      if (ofs == `OLBC_OFS_BANK_POINTER) begin
        isUnbanked = 1'b1;
      end
      if (ofs == `OLBC_OFS_GLOBAL_CONTROL) begin
        isUnbanked = 1'b1;
      end
    end
  endfunction

  function [7:0] maskWhen;
    input ovr;
    input [7:0] bits;
    begin
      maskWhen = bits;
      if (ovr) begin
        maskWhen = `OLBC_RESET_BYTE;
      end
    end
  endfunction

  // Excess-zero detection only matters on single rail with zero substitution
  function [7:0] ezGate;
    input [7:0] enable;
    input [7:0] rail;
    input [7:0] ami;
    begin
      ezGate = enable & rail & ~ami;
    end
  endfunction

  // Stored bit is active low; AMI lines carry no substitution codes to violate
  function [7:0] cvGate;
    input [7:0] disableBits;
    input [7:0] ami;
    begin
      cvGate = ~disableBits & ~ami;
    end
  endfunction

  // Fixed slices avoid a variable part-select on the read path
  function [7:0] byteOfSlot;
    input [3:0] slot;
    input [71:0] bytes;
    begin
      case (slot)
        `OLBC_SLOT_SINGLE_RAIL: byteOfSlot = bytes[7:0];
        `OLBC_SLOT_LINE_CODE: byteOfSlot = bytes[15:8];
        `OLBC_SLOT_RX_POWER_DOWN: byteOfSlot = bytes[23:16];
        `OLBC_SLOT_TX_POWER_DOWN: byteOfSlot = bytes[31:24];
        `OLBC_SLOT_EXCESS_ZERO: byteOfSlot = bytes[39:32];
        `OLBC_SLOT_CODE_VIOL_DIS: byteOfSlot = bytes[47:40];
        `OLBC_SLOT_JA_ENABLE: byteOfSlot = bytes[55:48];
        `OLBC_SLOT_JA_POSITION: byteOfSlot = bytes[63:56];
        `OLBC_SLOT_JA_DEPTH: byteOfSlot = bytes[71:64];
        default: byteOfSlot = `OLBC_RESET_BYTE;
      endcase
    end
  endfunction

  always @* begin
    wrSlot = slotOf(bankPointer, regAddr);
    rdSlot = slotOf(bankPointer, regAddr);
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  assign ptrHit = (regAddr == `OLBC_OFS_BANK_POINTER);
  assign gcHit = (regAddr == `OLBC_OFS_GLOBAL_CONTROL);
  assign storeWrEn = regWrite && !isUnbanked(regAddr);

  olbc_reg_store uStore (
    .clock(clock),
    .srst(srst),
    .wrEn(storeWrEn),
    .wrSlot(wrSlot),
    .wrData(regWrData),
    .allBytes(allBytes)
  );

  assign srByte = byteOfSlot(`OLBC_SLOT_SINGLE_RAIL, allBytes);
  assign lcByte = byteOfSlot(`OLBC_SLOT_LINE_CODE, allBytes);
  assign rpByte = byteOfSlot(`OLBC_SLOT_RX_POWER_DOWN, allBytes);
  assign tpByte = byteOfSlot(`OLBC_SLOT_TX_POWER_DOWN, allBytes);
  assign ezByte = byteOfSlot(`OLBC_SLOT_EXCESS_ZERO, allBytes);
  assign cvByte = byteOfSlot(`OLBC_SLOT_CODE_VIOL_DIS, allBytes);
  assign jeByte = byteOfSlot(`OLBC_SLOT_JA_ENABLE, allBytes);
  assign jpByte = byteOfSlot(`OLBC_SLOT_JA_POSITION, allBytes);
  assign jdByte = byteOfSlot(`OLBC_SLOT_JA_DEPTH, allBytes);

  assign codeOverride = globalControl[`OLBC_GLOBAL_CODE_OVERRIDE_BIT];
  assign jaGlobal = globalControl[`OLBC_GLOBAL_JITTER_ATTEN_ENABLE_BIT];
  assign depthGlobal = globalControl[`OLBC_GC_DEPTH_BIT];

  // ----------------------------------------
  // Pointer, global control and read path
  // ----------------------------------------
  // Pointer and global control are unbanked so software can always switch back
  always @* begin
    bankPointer_d = bankPointer;
    if (regWrite && ptrHit) begin
      bankPointer_d = regWrData;
    end
  end

  always @* begin
    globalControl_d = globalControl;
    if (regWrite && gcHit) begin
      globalControl_d = regWrData[`OLBC_GC_WIDTH-1:0];
    end
  end

  // ----------------------------------------
  // Read data selection
  // ----------------------------------------

  always @* begin
    rdData_d = `OLBC_RESET_BYTE;
    if (regAddr == `OLBC_OFS_BANK_POINTER) begin
      rdData_d = bankPointer;
    end else if (regAddr == `OLBC_OFS_GLOBAL_CONTROL) begin
      rdData_d = {5'h0_0, globalControl};
    end else if (rdSlot != `OLBC_SLOT_NONE) begin
      rdData_d = byteOfSlot(rdSlot, allBytes);
    end else begin
      rdData_d = `OLBC_RESET_BYTE;
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      bankPointer <= `OLBC_BANK_PRIMARY;
      globalControl <= `OLBC_RESET_GC;
      regRdData <= `OLBC_RESET_BYTE;
    end else begin
      bankPointer <= bankPointer_d;
      globalControl <= globalControl_d;
      // Data stand only in the cycle after the read strobe
      regRdData <= regRead ? rdData_d : `OLBC_RESET_BYTE;
    end
  end

  // ----------------------------------------
  // Per-channel effective controls
  // ----------------------------------------
  // Under override the per-channel code bits are ignored; the global mode rules
  always @* begin
    amiEffective = maskWhen(codeOverride, lcByte);
    singleRail_d = srByte;
    amiCoding_d = amiEffective;
    rxPowerDown_d = rpByte;
    txPowerDown_d = tpByte;
    excessZeroDetect_d = ezGate(ezByte, srByte, amiEffective);
    codeViolDetect_d = maskWhen(codeOverride, cvGate(cvByte, lcByte));
    jitterAttenOn_d = maskWhen(jaGlobal, jeByte);
    jitterAttenRxPath_d = maskWhen(jaGlobal, jpByte);
    jitterDepth128_d = maskWhen(depthGlobal, jdByte);
  end

  // ----------------------------------------
  // Secondary bank outputs
  // ----------------------------------------
  // Registered copies lag the store by one cycle; outputs stay glitch free
  always @(posedge clock) begin
    if (srst) begin
      singleRail <= `OLBC_RESET_BYTE;
      amiCoding <= `OLBC_RESET_BYTE;
      rxPowerDown <= `OLBC_RESET_BYTE;
      txPowerDown <= `OLBC_RESET_BYTE;
      excessZeroDetect <= `OLBC_RESET_BYTE;
      codeViolDetect <= `OLBC_RESET_BYTE;
    end else begin
      singleRail <= singleRail_d;
      amiCoding <= amiCoding_d;
      rxPowerDown <= rxPowerDown_d;
      txPowerDown <= txPowerDown_d;
      excessZeroDetect <= excessZeroDetect_d;
      codeViolDetect <= codeViolDetect_d;
    end
  end

  // ----------------------------------------
  // Individual bank outputs
  // ----------------------------------------
  always @(posedge clock) begin
    if (srst) begin
      jitterAttenOn <= `OLBC_RESET_BYTE;
      jitterAttenRxPath <= `OLBC_RESET_BYTE;
      jitterDepth128 <= `OLBC_RESET_BYTE;
    end else begin
      jitterAttenOn <= jitterAttenOn_d;
      jitterAttenRxPath <= jitterAttenRxPath_d;
      jitterDepth128 <= jitterDepth128_d;
    end
  end
endmodule // olbc_channel_config

/* bench/olbc_channel_config_checker.sv */
// Port-level assertions for the banked channel configuration block
`timescale 1ns/100ps
module olbc_channel_config_checker (
  input wire clock, input wire srst, input wire [7:0] regAddr, input wire [7:0] regWrData,
  input wire regWrite, input wire regRead, input wire [7:0] regRdData,
  input wire [7:0] bankPointer, input wire [7:0] singleRail, input wire [7:0] amiCoding,
  input wire [7:0] rxPowerDown, input wire [7:0] txPowerDown, input wire [7:0] excessZeroDetect,
  input wire [7:0] codeViolDetect, input wire [7:0] jitterAttenOn,
  input wire [7:0] jitterAttenRxPath, input wire [7:0] jitterDepth128,
  input wire [2:0] globalControl
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  wire secWr = regWrite && bankPointer == 8'hAA;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_read_idle: assert property (!regRead |=> regRdData == 8'h00)
    else $error("read data not zero outside read slot");
  chk_bank_write: assert property (regWrite && regAddr == 8'h1F |=> bankPointer == $past(regWrData))
    else $error("bank pointer not loaded");
  chk_ptr_read: assert property (regRead && regAddr == 8'h1F |=> regRdData == $past(bankPointer))
    else $error("bank pointer readback wrong");
  chk_rail_write: assert property (secWr && regAddr == 8'h00 |=> ##1 singleRail == $past(regWrData, 2))
    else $error("rail select output wrong");
  chk_rxpd_write: assert property (secWr && regAddr == 8'h03 |=> ##1 rxPowerDown == $past(regWrData, 2))
    else $error("receive power-down output wrong");
  chk_txpd_write: assert property (secWr && regAddr == 8'h04 |=> ##1 txPowerDown == $past(regWrData, 2))
    else $error("transmit power-down output wrong");
  // Output flop lags the control bit, so it must have stood two cycles first
  chk_code_override: assert property (globalControl[0] && $past(globalControl[0]) && $past(globalControl[0], 2) |-> (amiCoding | codeViolDetect) == 8'h00)
    else $error("code override not applied");
  chk_ezd_gate: assert property ((excessZeroDetect & (~singleRail | amiCoding)) == 8'h00)
    else $error("excess-zero detect outside single rail HDB3");
  chk_ja_override: assert property (globalControl[1] && $past(globalControl[1]) && $past(globalControl[1], 2) |-> (jitterAttenOn | jitterAttenRxPath) == 8'h00)
    else $error("global attenuator enable not applied");
  chk_depth_override: assert property (globalControl[2] && $past(globalControl[2]) && $past(globalControl[2], 2) |-> jitterDepth128 == 8'h00)
    else $error("global depth override not applied");
  cov_sec_write: cover property (secWr);
  cov_override: cover property (globalControl == 3'h7);
  cov_ptr_read: cover property (regRead && regAddr == 8'h1F);
endmodule // olbc_channel_config_checker

bind olbc_channel_config olbc_channel_config_checker chk_u (.clock, .srst, .regAddr, .regWrData,
  .regWrite, .regRead, .regRdData, .bankPointer, .singleRail, .amiCoding, .rxPowerDown,
  .txPowerDown, .excessZeroDetect, .codeViolDetect, .jitterAttenOn, .jitterAttenRxPath,
  .jitterDepth128, .globalControl);

/* bench/olbc_channel_config_tb.sv */
// Self-checking bench for the banked channel configuration block
`timescale 1ns/100ps
module olbc_channel_config_tb;
  reg clock = 0, srst = 1, regWrite = 0, regRead = 0, rdPend = 0;
  reg [7:0] regAddr = 8'h00, regWrData = 8'h00;
  wire [7:0] regRdData, bankPointer, singleRail, amiCoding, rxPowerDown, txPowerDown;
  wire [7:0] excessZeroDetect, codeViolDetect, jitterAttenOn, jitterAttenRxPath, jitterDepth128;
  wire [2:0] globalControl;
  reg [7:0] expQ[$];
  reg [7:0] s[0:6];
  reg [7:0] j[0:3];
  integer mismatches = 0, samples_checked = 0, i;
  always #20 clock = ~clock;
  olbc_channel_config dut_u (.clock, .srst, .regAddr, .regWrData, .regWrite, .regRead,
    .regRdData, .bankPointer, .singleRail, .amiCoding, .rxPowerDown, .txPowerDown,
    .excessZeroDetect, .codeViolDetect, .jitterAttenOn, .jitterAttenRxPath, .jitterDepth128,
    .globalControl);
  // ----------------------------------------
  // Bus tasks and checks
  // ----------------------------------------
  task chk(input string what, input [7:0] expv, input [7:0] got);
    samples_checked++;
    if (got !== expv) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, expv, got);
    end
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Strobe dropped then one idle edge, so no signal is assigned twice per step
  task wr(input [7:0] a, input [7:0] v);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    @(posedge clock);
  endtask
  task rd(input [7:0] a, input [7:0] e);
    regAddr <= a;
    regRead <= 1'b1;
    expQ.push_back(e);
    @(posedge clock);
    regRead <= 1'b0;
    @(posedge clock);
  endtask
  task settle;
    repeat (3) @(posedge clock);
  endtask
  always @(posedge clock) begin
    rdPend <= regRead;
    if (rdPend) chk("regRdData", expQ.pop_front(), regRdData);
  end
  initial begin
    repeat (3000) @(posedge clock);
    mismatches++;
    stop_test;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(26221));
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    chk("bankPointer", 8'h00, bankPointer);
    rd(8'h1F, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'h1F, 8'hAA);
    for (i = 0; i < 7; i++) rd(i[7:0], 8'h00);
    for (i = 0; i < 7; i++) begin
      s[i] = 8'($urandom);
      wr(i[7:0], s[i]);
    end
    s[2] = 8'h00;
    for (i = 0; i < 7; i++) rd(i[7:0], s[i]);
    settle;
    chk("singleRail", s[0], singleRail);
    chk("amiCoding", s[1], amiCoding);
    chk("rxPowerDown", s[3], rxPowerDown);
    chk("txPowerDown", s[4], txPowerDown);
    chk("excessZeroDetect", s[5] & s[0] & ~s[1], excessZeroDetect);
    chk("codeViolDetect", ~s[6] & ~s[1], codeViolDetect);
    wr(8'h1F, 8'h01);
    for (i = 0; i < 4; i++) begin
      j[i] = 8'($urandom);
      wr(i[7:0], j[i]);
    end
    j[3] = 8'h00;
    for (i = 0; i < 4; i++) rd(i[7:0], j[i]);
    settle;
    chk("jitterAttenOn", j[0], jitterAttenOn);
    chk("jitterAttenRxPath", j[1], jitterAttenRxPath);
    chk("jitterDepth128", j[2], jitterDepth128);
    wr(8'h1E, 8'hFF);
    rd(8'h1E, 8'h07);
    settle;
    chk("globalControl", 8'h07, {5'h00, globalControl});
    chk("jitterAttenOn", 8'h00, jitterAttenOn);
    chk("jitterAttenRxPath", 8'h00, jitterAttenRxPath);
    chk("jitterDepth128", 8'h00, jitterDepth128);
    chk("amiCoding", 8'h00, amiCoding);
    chk("codeViolDetect", 8'h00, codeViolDetect);
    chk("excessZeroDetect", s[5] & s[0], excessZeroDetect);
    wr(8'h1F, 8'h02);
    rd(8'h00, 8'h00);
    rd(8'h1F, 8'h02);
    stop_test;
  end
endmodule // olbc_channel_config_tb
